//--- common/acp_map.vh
// acp_map.vh: constants for the ate control port block
// assumes inclusion by bare name from design files
`ifndef ACP_MAP_VH
`define ACP_MAP_VH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ACP_CLK_MHZ 250
`define ACP_HOLD_MS 2000
// hold count in clock cycles: ACP_HOLD_MS * 1000 * ACP_CLK_MHZ
`define ACP_HOLD_CYCLES 30'd500000000
// enabled edges after reset before a sync chain holds pin samples
`define ACP_SYNC_FILL 2'h3

// ----------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------
`define ACP_CODE_W 5
`define ACP_HOLD_W 30
`define ACP_FLAG_IDLE 1'b1

`endif

//--- hdl/acp_ctrl.v
// acp_ctrl.v: start/stop, project select and status logic of the
// external control port
// assumes pins are asynchronous to sys_clk; engine is on sys_clk
// assumes clk_en high in normal running; low freezes every register
// assumes the engine answers a launch with one run_done pulse and a
// run_ok level that is valid in that same cycle
// assumes the equipment sets the project code before start falls
//
// Contract
// - start request is active low; a fall to low launches or stops a run
// - start held low longer than two seconds enters standalone mode
// - five bit project code selects one of 32 projects, code = number
// - pass, busy and error outputs are active low
// - strap high at power-up puts the device in standalone mode
`timescale 1ns/10ps
`include "acp_map.vh"

module acp_ctrl #(
    parameter [`ACP_HOLD_W-1:0] HOLD_CYCLES = `ACP_HOLD_CYCLES
) (
    // clock, reset, enable
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    // ate pins
    input wire start_req_n,
    input wire [`ACP_CODE_W-1:0] project_code_in,
    input wire standalone_strap,
    // programming engine side
    input wire run_done,
    input wire run_ok,
    output reg run_launch,
    output reg run_abort,
    output reg [`ACP_CODE_W-1:0] run_project,
    output reg standalone_mode,
    // ate status pins
    output reg run_active_n,
    output reg pass_flag_n,
    output reg fail_flag_n
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // true where stages two and three of a chain agree
    function agree;
        input stage2;
        input stage3;
        begin
            agree = (stage2 == stage3);
        end
    endfunction

    // settled level of one synchronised pin: stage three is taken
    // only where stages two and three agree, so a pin caught in the
    // middle of a change keeps its old level one more cycle
    function settle;
        input stage2;
        input stage3;
        input old_lvl;
        begin
            settle = agree(stage2, stage3) ? stage3 : old_lvl;
        end
    endfunction

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // every ate pin is asynchronous to sys_clk; each passes three
    // flip-flops and only stages two and three are read beyond the
    // chain, so a metastable first stage never reaches the logic
    reg [2:0] start_sync_reg;
    reg [2:0] strap_sync_reg;
    reg [`ACP_CODE_W-1:0] code_s1_reg, code_s2_reg, code_s3_reg;
    reg [`ACP_CODE_W-1:0] code_lvl_reg;
    reg start_lvl_reg;
    reg [1:0] fill_cnt_reg;
    reg strap_taken_reg;
    reg [`ACP_HOLD_W-1:0] hold_cnt_reg;
    reg hold_long_reg;
    integer bit_idx;

    // chains hold real pin samples once three enabled edges passed
    wire chain_full = (fill_cnt_reg == `ACP_SYNC_FILL);

    // three stages; a level counts once stages two and three agree
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            start_sync_reg <= 3'h7;
            strap_sync_reg <= 3'h0;
            code_s1_reg <= {`ACP_CODE_W{1'b0}};
            code_s2_reg <= {`ACP_CODE_W{1'b0}};
            code_s3_reg <= {`ACP_CODE_W{1'b0}};
            code_lvl_reg <= {`ACP_CODE_W{1'b0}};
            start_lvl_reg <= 1'b1;
            fill_cnt_reg <= 2'h0;
        end else if (clk_en) begin
            start_sync_reg <= {start_sync_reg[1:0], start_req_n};
            strap_sync_reg <= {strap_sync_reg[1:0], standalone_strap};
            code_s1_reg <= project_code_in;
            code_s2_reg <= code_s1_reg;
            code_s3_reg <= code_s2_reg;
            // each code bit settles on its own, like a one-bit pin;
            // the code is steady long before start falls, so the
            // word is whole by the time it is captured
            for (bit_idx = 0; bit_idx < `ACP_CODE_W;
                    bit_idx = bit_idx + 1) begin
                code_lvl_reg[bit_idx] <= settle(code_s2_reg[bit_idx],
                    code_s3_reg[bit_idx], code_lvl_reg[bit_idx]);
            end
            start_lvl_reg <= settle(start_sync_reg[1], start_sync_reg[2],
                start_lvl_reg);
            if (!chain_full)
                fill_cnt_reg <= fill_cnt_reg + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // request handling
    // ------------------------------------------------------------
    wire start_low = ~start_lvl_reg;
    reg start_low_d_reg;
    wire start_fall = start_low & ~start_low_d_reg;

    // hold timer and standalone entry; strap caught once after reset
    // a long hold has already launched a run at its fall; that run
    // goes on, and only the operating mode changes at the limit
    // the mode is sticky: only a reset brings the block back
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            start_low_d_reg <= 1'b0;
            hold_cnt_reg <= {`ACP_HOLD_W{1'b0}};
            hold_long_reg <= 1'b0;
            strap_taken_reg <= 1'b0;
            standalone_mode <= 1'b0;
        end else if (clk_en) begin
            start_low_d_reg <= start_low;
            if (!start_low) begin
                hold_cnt_reg <= {`ACP_HOLD_W{1'b0}};
                hold_long_reg <= 1'b0;
            end else if (hold_cnt_reg < HOLD_CYCLES) begin
                hold_cnt_reg <= hold_cnt_reg + 1'b1;
            end else if (!hold_long_reg) begin
                hold_long_reg <= 1'b1;
                standalone_mode <= 1'b1;
            end
            // the strap is read once, after the chain has filled with
            // real pin samples; reset values would otherwise be taken
            if (!strap_taken_reg && chain_full
                && agree(strap_sync_reg[1], strap_sync_reg[2])) begin
                strap_taken_reg <= 1'b1;
                if (strap_sync_reg[2])
                    standalone_mode <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // run state and status pins
    // ------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RUN = 2'h1;
    reg [1:0] state_reg;

    // fall of start launches when idle, stops when running
    // a stop wins over a completion in the same cycle: the equipment
    // asked for the run to end, so the result reported is an error
    // pass and error clear only at the next launch, so the equipment
    // may read them at leisure once busy has gone high
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            run_launch <= 1'b0;
            run_abort <= 1'b0;
            run_project <= {`ACP_CODE_W{1'b0}};
            run_active_n <= `ACP_FLAG_IDLE;
            pass_flag_n <= `ACP_FLAG_IDLE;
            fail_flag_n <= `ACP_FLAG_IDLE;
        end else if (clk_en) begin
            run_launch <= 1'b0;
            run_abort <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (start_fall) begin
                        state_reg <= ST_RUN;
                        run_launch <= 1'b1;
                        run_project <= code_lvl_reg;
                        run_active_n <= 1'b0;
                        pass_flag_n <= `ACP_FLAG_IDLE;
                        fail_flag_n <= `ACP_FLAG_IDLE;
                    end
                end
                ST_RUN: begin
                    if (start_fall) begin
                        state_reg <= ST_IDLE;
                        run_abort <= 1'b1;
                        run_active_n <= `ACP_FLAG_IDLE;
                        fail_flag_n <= 1'b0;
                    end else if (run_done) begin
                        state_reg <= ST_IDLE;
                        run_active_n <= `ACP_FLAG_IDLE;
                        pass_flag_n <= ~run_ok;
                        fail_flag_n <= run_ok;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

endmodule // acp_ctrl

//--- verification/acp_ctrl_monitor.sv
// checker for acp_ctrl ports; bound to every acp_ctrl instance
// checks are off while rst_n or clk_en is low
`timescale 1ns/10ps
module acp_ctrl_monitor (
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    input wire run_done,
    input wire run_ok,
    input wire run_launch,
    input wire run_abort,
    input wire [4:0] run_project,
    input wire standalone_mode,
    input wire run_active_n,
    input wire pass_flag_n,
    input wire fail_flag_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n || !clk_en);
    sequence s_run_end;
        run_done && !run_active_n;
    endsequence
    a_launch_busy: assert property (run_launch |-> !run_active_n && pass_flag_n && fail_flag_n) else $error("launch status");
    a_launch_pulse: assert property (run_launch |=> !run_launch) else $error("launch pulse");
    a_code_snap: assert property ($changed(run_project) |-> run_launch) else $error("code changed");
    a_one_result: assert property (pass_flag_n || fail_flag_n) else $error("two results");
    a_done_flags: assert property (s_run_end |=> run_active_n && pass_flag_n != $past(run_ok) && fail_flag_n == $past(run_ok)) else $error("done flags");
    a_abort_err: assert property (run_abort |-> ##[0:1] (!fail_flag_n && run_active_n)) else $error("abort result");
    a_mode_sticky: assert property (standalone_mode |=> standalone_mode) else $error("mode lost");
endmodule // acp_ctrl_monitor
bind acp_ctrl acp_ctrl_monitor acp_ctrl_monitor_i (.*);

//--- verification/acp_ctrl_tb_top.sv
// testbench for acp_ctrl with a behavioural engine
// assumes HOLD_CYCLES shortened to 20 cycles for a quick run
`timescale 1ns/10ps
module acp_ctrl_tb_top;
    logic sys_clk = 0, rst_n = 0, start_n = 1, strap = 0, ok_in = 0, en = 1;
    logic [4:0] code = 5'h00;
    wire run_done, run_ok, run_launch, run_abort, standalone_mode;
    wire run_active_n, pass_flag_n, fail_flag_n;
    wire [4:0] run_project;
    integer miscompares = 0, n_checks = 0;
    acp_ctrl #(.HOLD_CYCLES(30'd20)) acp_ctrl_i (.sys_clk(sys_clk),
        .rst_n(rst_n), .clk_en(en), .start_req_n(start_n),
        .project_code_in(code), .standalone_strap(strap),
        .run_done(run_done), .run_ok(run_ok), .run_launch(run_launch),
        .run_abort(run_abort), .run_project(run_project),
        .standalone_mode(standalone_mode), .run_active_n(run_active_n),
        .pass_flag_n(pass_flag_n), .fail_flag_n(fail_flag_n));
    acp_engine_model acp_engine_model_i (.sys_clk(sys_clk),
        .run_launch(run_launch), .ok_in(ok_in), .run_done(run_done),
        .run_ok(run_ok));
    initial forever #2 sys_clk = ~sys_clk;
    task chk(input logic c);
        n_checks++;
        if (c !== 1'b1) begin
            miscompares++;
            $display("[ERR] %0t mismatch", $time);
        end
    endtask
    task close_out;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // one run: start pulse of hold cycles, optional abort pulse
    task go(input logic [4:0] c, input logic ok, ab, input integer hold);
        integer i;
        logic p;
        code = c;
        ok_in = ok;
        start_n = 0;
        p = ok && !ab;
        for (i = 0; i < 12 && run_launch !== 1'b1; i++) @(negedge sys_clk);
        chk(run_project === c && run_active_n === 1'b0);
        repeat (hold) @(negedge sys_clk);
        start_n = 1;
        repeat (6) @(negedge sys_clk);
        start_n = !ab;
        repeat (8) @(negedge sys_clk);
        start_n = 1;
        repeat (6) @(negedge sys_clk);
        for (i = 0; i < 60 && run_active_n !== 1'b1; i++) @(negedge sys_clk);
        chk(pass_flag_n === !p && fail_flag_n === p);
    endtask
    initial begin
        #20000;
        miscompares++;
        close_out;
    end
    // reset, pass/fail/abort runs, long hold, then strap at reset
    initial begin
        repeat (5) @(negedge sys_clk);
        rst_n = 1;
        chk(run_active_n & pass_flag_n & fail_flag_n);
        go(5'h00, 1, 0, 8);
        go(5'h04, 0, 0, 8);
        go(5'h15, 1, 1, 8);
        chk(standalone_mode === 1'b0);
        go(5'h1f, 1, 0, 30);
        chk(standalone_mode === 1'b1);
        en = 0;
        start_n = 0;
        repeat (10) @(negedge sys_clk);
        chk(run_launch === 1'b0 && run_active_n === 1'b1);
        start_n = 1;
        repeat (4) @(negedge sys_clk);
        en = 1;
        repeat (10) @(negedge sys_clk);
        chk(run_active_n === 1'b1);
        strap = 1;
        rst_n = 0;
        repeat (5) @(negedge sys_clk);
        rst_n = 1;
        chk(standalone_mode === 1'b0);
        repeat (10) @(negedge sys_clk);
        chk(standalone_mode === 1'b1);
        close_out;
    end
endmodule // acp_ctrl_tb_top

//--- verification/acp_engine_model.sv
// engine model: answers each launch with run_done after dly cycles
// assumes the same clock as acp_ctrl; a new launch restarts the count
`timescale 1ns/10ps
module acp_engine_model #(parameter DLY = 40) (
    // clock and engine handshake
    input wire sys_clk,
    input wire run_launch,
    input wire ok_in,
    output reg run_done = 1'b0,
    output reg run_ok = 1'b0
);
    integer cnt = 0;
    // run_ok toggles outside done so a stale value is never read
    always @(posedge sys_clk) begin
        run_done <= (cnt == 1);
        run_ok <= (cnt == 1) ? ok_in : ~run_ok;
        cnt <= run_launch ? DLY : (cnt > 0 ? cnt - 1 : 0);
    end
endmodule // acp_engine_model
